// *** include/bst_pkg.sv ***
// shared types and constants for the boundary-scan test port
package bst_pkg;
	localparam int IR_W = 4;
	localparam int ID_W = 32;
	// instruction codes
	localparam logic [3:0] INS_EXTEST = 4'h0;
	localparam logic [3:0] INS_SAMPLE = 4'h1;
	localparam logic [3:0] INS_IDCODE = 4'h2;
	localparam logic [3:0] INS_FLOAT = 4'h3;
	localparam logic [3:0] INS_BYPASS = 4'hF;
	// identification field layout
	localparam int ID_FIXED_BIT = 0;
	localparam int ID_MAKER_LSB = 1;
	localparam int ID_MAKER_W = 11;
	localparam int ID_PART_LSB = 12;
	localparam int ID_PART_W = 16;
	localparam int ID_VER_LSB = 28;
	localparam int ID_VER_W = 4;
	// reset and capture values
	localparam logic [3:0] IR_RESET = 4'h2;
	localparam logic [1:0] IR_CAPTURE = 2'h1;
	localparam int RESET_ONES = 5;
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
		ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} bst_state_t;
	// actions from the controller: reset is a level, the others last one cycle on the sampled clock rise
	typedef struct packed {
		logic reset;
		logic cap_dr;
		logic shift_dr;
		logic upd_dr;
		logic cap_ir;
		logic shift_ir;
		logic upd_ir;
	} bst_ctl_t;
	// selected test data register and output mode flags
	typedef struct packed {
		logic boundary;
		logic ident;
		logic bypass;
		logic extest;
		logic outputs_float;
	} bst_sel_t;
endpackage

// *** hw/bst_sync.sv ***
// two-flop synchroniser for one pin
`timescale 1ns/10ps
module bst_sync #(
	parameter logic INIT = 1'b0
) (
	// clocking
	input wire logic clk,
	input wire logic rst,
	// data
	input wire logic d,
	output logic q
);
	logic meta;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= INIT;
			q <= INIT;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// *** hw/bst_shreg.sv ***
// capture/shift/update register stage of a scan chain
`timescale 1ns/10ps
module bst_shreg #(
	parameter int W = 8
) (
	// clocking
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic capture,
	input wire logic shift,
	input wire logic update,
	// data
	input wire logic [W-1:0] par_in,
	input wire logic ser_in,
	output logic [W-1:0] shift_q,
	output logic [W-1:0] par_out
);
	logic [W-1:0] next_shift;
	assign next_shift = capture ? par_in : (shift ? {ser_in, shift_q[W-1:1]} : shift_q);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_q <= '0;
			par_out <= '0;
		end else begin
			shift_q <= next_shift;
			if (update) begin
				par_out <= shift_q;
			end
		end
	end
endmodule

// *** hw/bst_tap.sv ***
// boundary-scan test access port: controller, instruction and data registers
`timescale 1ns/10ps
module bst_tap #(
	parameter int BSR_W = 8,
	parameter logic [10:0] MAKER_ID = 11'h055, // arbitrary value
	parameter logic [15:0] PART_ID = 16'h1234, // arbitrary value
	parameter logic [3:0] VERSION_ID = 4'h1 // arbitrary value
) (
	// system clock and reset
	input wire logic clk,
	input wire logic rst,
	// test port pins
	input wire logic test_clock_input,
	input wire logic test_mode_select,
	input wire logic test_data_in,
	input wire logic test_reset_n,
	output logic test_data_out,
	output logic test_data_out_oe,
	// boundary cells towards pins and core
	input wire logic [BSR_W-1:0] boundary_capture,
	output logic [BSR_W-1:0] boundary_drive,
	output logic boundary_extest,
	output logic outputs_float,
	// buffer gating and current instruction
	output logic port_was_reset,
	output logic [3:0] current_instruction
);
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic trst_n_s;
	logic tck_d;
	logic tck_rise;
	logic tck_fall;
	bst_pkg::bst_state_t state;
	bst_pkg::bst_state_t next_state;
	bst_pkg::bst_ctl_t ctl;
	bst_pkg::bst_sel_t sel;
	logic [3:0] ir_shift;
	logic [3:0] ir_q;
	logic byp;
	logic [BSR_W-1:0] bsr_shift;
	logic [bst_pkg::ID_W-1:0] id_shift;
	logic [bst_pkg::ID_W-1:0] id_value;
	logic dr_bit;
	logic next_tdo;
	logic soft_reset;
	logic async_trst;
	logic [2:0] tms_ones;
	logic ones_full;
	logic fifth_one;
	// pins arrive on the link's own timing: two flops each
	// clock and test reset start high: no false rise or port reset after rst
	bst_sync #(.INIT(1'b1)) u_sync_tck (.clk(clk), .rst(rst), .d(test_clock_input), .q(tck_s));
	bst_sync u_sync_tms (.clk(clk), .rst(rst), .d(test_mode_select), .q(tms_s));
	bst_sync u_sync_tdi (.clk(clk), .rst(rst), .d(test_data_in), .q(tdi_s));
	bst_sync #(.INIT(1'b1)) u_sync_trst (.clk(clk), .rst(rst), .d(test_reset_n), .q(trst_n_s));
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tck_d <= 1'b1;
		end else begin
			tck_d <= tck_s;
		end
	end
	assign tck_rise = tck_s & ~tck_d;
	assign tck_fall = ~tck_s & tck_d;
	// test reset pin is handled synchronously after the synchroniser
	assign async_trst = ~trst_n_s;
	assign soft_reset = async_trst;
	// controller transitions
	always_comb begin
		next_state = state;
		unique case (state)
			bst_pkg::ST_RESET: next_state = tms_s ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
			bst_pkg::ST_IDLE: next_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			bst_pkg::ST_SEL_DR: next_state = tms_s ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
			bst_pkg::ST_CAP_DR: next_state = tms_s ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
			bst_pkg::ST_SHIFT_DR: next_state = tms_s ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
			bst_pkg::ST_EXIT1_DR: next_state = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAUSE_DR;
			bst_pkg::ST_PAUSE_DR: next_state = tms_s ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
			bst_pkg::ST_EXIT2_DR: next_state = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHIFT_DR;
			bst_pkg::ST_UPD_DR: next_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			bst_pkg::ST_SEL_IR: next_state = tms_s ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
			bst_pkg::ST_CAP_IR: next_state = tms_s ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
			bst_pkg::ST_SHIFT_IR: next_state = tms_s ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
			bst_pkg::ST_EXIT1_IR: next_state = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAUSE_IR;
			bst_pkg::ST_PAUSE_IR: next_state = tms_s ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
			bst_pkg::ST_EXIT2_IR: next_state = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHIFT_IR;
			bst_pkg::ST_UPD_IR: next_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
		endcase
	end
	// a state change only on a sampled clock rise, a test reset or rst
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= bst_pkg::ST_RESET;
		end else if (soft_reset) begin
			state <= bst_pkg::ST_RESET;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end
	// clocked actions happen on each rise taken while in the acting state
	assign ctl.reset = soft_reset | (state == bst_pkg::ST_RESET);
	assign ctl.cap_dr = tck_rise & (state == bst_pkg::ST_CAP_DR);
	assign ctl.shift_dr = tck_rise & (state == bst_pkg::ST_SHIFT_DR);
	assign ctl.upd_dr = tck_rise & (state == bst_pkg::ST_UPD_DR);
	assign ctl.cap_ir = tck_rise & (state == bst_pkg::ST_CAP_IR);
	assign ctl.shift_ir = tck_rise & (state == bst_pkg::ST_SHIFT_IR);
	assign ctl.upd_ir = tck_rise & (state == bst_pkg::ST_UPD_IR);
	// instruction register, LSB nearest the serial output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ir_shift <= '0;
			ir_q <= bst_pkg::IR_RESET;
		end else if (ctl.reset) begin
			ir_shift <= '0;
			ir_q <= bst_pkg::IR_RESET;
		end else begin
			if (ctl.cap_ir) begin
				ir_shift <= {2'h0, bst_pkg::IR_CAPTURE};
			end else if (ctl.shift_ir) begin
				ir_shift <= {tdi_s, ir_shift[3:1]};
			end
			if (ctl.upd_ir) begin
				ir_q <= ir_shift;
			end
		end
	end
	// decode; unknown codes fall to bypass
	assign sel.boundary = (ir_q == bst_pkg::INS_EXTEST) | (ir_q == bst_pkg::INS_SAMPLE);
	assign sel.ident = ir_q == bst_pkg::INS_IDCODE;
	assign sel.bypass = ~sel.boundary & ~sel.ident;
	assign sel.extest = ir_q == bst_pkg::INS_EXTEST;
	assign sel.outputs_float = ir_q == bst_pkg::INS_FLOAT;
	// bypass stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			byp <= 1'b0;
		end else if (sel.bypass & ctl.cap_dr) begin
			byp <= 1'b0;
		end else if (sel.bypass & ctl.shift_dr) begin
			byp <= tdi_s;
		end
	end
	// boundary register: only touched while selected, so others hold
	bst_shreg #(.W(BSR_W)) u_bsr (
		.clk(clk),
		.rst(rst),
		.capture(sel.boundary & ctl.cap_dr),
		.shift(sel.boundary & ctl.shift_dr),
		.update(sel.boundary & ctl.upd_dr),
		.par_in(boundary_capture),
		.ser_in(tdi_s),
		.shift_q(bsr_shift),
		.par_out(boundary_drive)
	);
	// identification register: capture loads the constant, no update
	assign id_value = {VERSION_ID, PART_ID, MAKER_ID, 1'b1};
	bst_shreg #(.W(bst_pkg::ID_W)) u_id (
		.clk(clk),
		.rst(rst),
		.capture(sel.ident & ctl.cap_dr),
		.shift(sel.ident & ctl.shift_dr),
		.update(1'b0),
		.par_in(id_value),
		.ser_in(tdi_s),
		.shift_q(id_shift),
		.par_out()
	);
	// common output mux, driven on the falling clock
	assign dr_bit = sel.boundary ? bsr_shift[0] : (sel.ident ? id_shift[0] : byp);
	assign next_tdo = (state == bst_pkg::ST_SHIFT_IR) ? ir_shift[0] : dr_bit;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			test_data_out <= 1'b0;
			test_data_out_oe <= 1'b0;
		end else if (tck_fall) begin
			test_data_out <= next_tdo;
			test_data_out_oe <= (state == bst_pkg::ST_SHIFT_DR) | (state == bst_pkg::ST_SHIFT_IR);
		end
	end
	// run of mode-select ones; rst alone is not a port reset
	assign ones_full = tms_ones == 3'(bst_pkg::RESET_ONES);
	assign fifth_one = tck_rise & tms_s & (tms_ones == 3'(bst_pkg::RESET_ONES - 1));
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tms_ones <= 3'h0;
		end else if (tck_rise & ~tms_s) begin
			tms_ones <= 3'h0;
		end else if (tck_rise & ~ones_full) begin
			tms_ones <= tms_ones + 3'h1;
		end
	end
	// buffer may run only once the port has seen reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_was_reset <= 1'b0;
		end else if (soft_reset | fifth_one) begin
			port_was_reset <= 1'b1;
		end
	end
	assign boundary_extest = sel.extest; // bypass leaves core path alone
	assign outputs_float = sel.outputs_float;
	assign current_instruction = ir_q;

	// checks
	int ones_cnt;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ones_cnt <= 0;
		end else if (tck_rise) begin
			ones_cnt <= tms_s ? ((ones_cnt < 7) ? ones_cnt + 1 : ones_cnt) : 0;
		end
	end
	AST_FIVE_ONES: assert property (@(posedge clk) disable iff (rst)
		(ones_cnt >= bst_pkg::RESET_ONES) |-> state == bst_pkg::ST_RESET)
		else $error("five mode-select ones did not reset the port");
	AST_NO_MOVE: assert property (@(posedge clk) disable iff (rst || soft_reset)
		!$past(tck_rise) |-> $stable(state))
		else $error("state changed without a clock rise");
	sequence seq_exit_high;
		tck_rise && tms_s && (state == bst_pkg::ST_EXIT1_DR || state == bst_pkg::ST_EXIT2_DR);
	endsequence
	sequence seq_boundary_shift;
		sel.boundary && ctl.shift_dr;
	endsequence
	AST_EXIT_UPD: assert property (@(posedge clk) disable iff (rst || soft_reset)
		seq_exit_high |=> state == bst_pkg::ST_UPD_DR)
		else $error("exit with mode select high missed update");
	AST_PAUSE_HOLD: assert property (@(posedge clk) disable iff (rst)
		(state == bst_pkg::ST_PAUSE_DR) |=> $stable(bsr_shift) && $stable(id_shift))
		else $error("data register moved during pause");
	AST_IR_HOLD: assert property (@(posedge clk) disable iff (rst || soft_reset)
		(state != bst_pkg::ST_UPD_IR && state != bst_pkg::ST_RESET) |=> $stable(ir_q))
		else $error("instruction changed outside update");
	AST_BYP_CLR: assert property (@(posedge clk) disable iff (rst)
		(sel.bypass && ctl.cap_dr) |=> byp == 1'b0)
		else $error("bypass stage not cleared at capture");
	AST_ID_CAP: assert property (@(posedge clk) disable iff (rst)
		(sel.ident && ctl.cap_dr) |=> id_shift[0] == 1'b1 && id_shift[31:28] == VERSION_ID)
		else $error("identification capture wrong");
	AST_FLOAT: assert property (@(posedge clk) disable iff (rst || soft_reset)
		(ctl.upd_ir && ir_shift == bst_pkg::INS_FLOAT) |=> outputs_float && !sel.boundary)
		else $error("float instruction not applied");
	AST_TDO_FALL: assert property (@(posedge clk) disable iff (rst)
		!$past(tck_fall) |-> $stable(test_data_out))
		else $error("serial output changed off a falling edge");
	AST_SHIFT_LSB: assert property (@(posedge clk) disable iff (rst)
		seq_boundary_shift |=> bsr_shift == {$past(tdi_s), $past(bsr_shift[BSR_W-1:1])})
		else $error("boundary shift not towards the low end");
	AST_CAP_BSR: assert property (@(posedge clk) disable iff (rst)
		(sel.boundary && ctl.cap_dr) |=> bsr_shift == $past(boundary_capture))
		else $error("boundary capture missed the pins");
	AST_UPD_LATCH: assert property (@(posedge clk) disable iff (rst)
		(sel.boundary && ctl.upd_dr) |=> boundary_drive == $past(bsr_shift))
		else $error("update did not load the output latches");
	AST_UNSEL: assert property (@(posedge clk) disable iff (rst)
		!sel.boundary |=> $stable(bsr_shift) && $stable(boundary_drive))
		else $error("unselected boundary register moved");
	AST_ID_UNSEL: assert property (@(posedge clk) disable iff (rst)
		!sel.ident |=> $stable(id_shift))
		else $error("unselected identification register moved");
	AST_BYP_SHIFT: assert property (@(posedge clk) disable iff (rst)
		(sel.bypass && ctl.shift_dr) |=> byp == $past(tdi_s))
		else $error("bypass stage did not take serial input");
	AST_IR_CAP: assert property (@(posedge clk) disable iff (rst || soft_reset)
		ctl.cap_ir |=> ir_shift == {2'h0, bst_pkg::IR_CAPTURE})
		else $error("instruction capture pattern wrong");
	AST_IR_SHIFT: assert property (@(posedge clk) disable iff (rst || soft_reset)
		ctl.shift_ir |=> ir_shift == {$past(tdi_s), $past(ir_shift[3:1])})
		else $error("instruction shift not towards the low end");
	AST_IR_UPD: assert property (@(posedge clk) disable iff (rst || soft_reset)
		ctl.upd_ir |=> ir_q == $past(ir_shift))
		else $error("update-instruction did not load the shifted code");
	AST_OE: assert property (@(posedge clk) disable iff (rst)
		(tck_fall && (state == bst_pkg::ST_SHIFT_DR || state == bst_pkg::ST_SHIFT_IR)) |=> test_data_out_oe)
		else $error("serial output not enabled while shifting");
	AST_SOFT_RESET: assert property (@(posedge clk) disable iff (rst)
		soft_reset |=> state == bst_pkg::ST_RESET && ir_q == bst_pkg::IR_RESET)
		else $error("test reset pin did not reset the port");
	AST_GATE: assert property (@(posedge clk) disable iff (rst)
		$rose(port_was_reset) |-> $past(soft_reset) || $past(fifth_one))
		else $error("buffer released without a port reset");
	AST_GATE_HOLD: assert property (@(posedge clk) disable iff (rst)
		port_was_reset |=> port_was_reset)
		else $error("buffer release flag dropped");
endmodule

// *** tb/bst_ctl_model.sv ***
// behavioural scan controller that drives the test port pins
`timescale 1ns/10ps
module bst_ctl_model (
	// clocking
	input wire logic clk,
	// scan pins
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input wire logic tdo
);
	initial begin
		tck = 1'b1;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b1;
	end

	// one test clock period of 8 clk; the clock stands high between steps
	task automatic step(input logic m, input logic d, output logic q);
		@(posedge clk);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clk);
		tck <= 1'b1;
		#1;
		q = tdo;
		repeat (3) @(posedge clk);
	endtask

	// port is not self-initialising, so the controller resets it first
	task automatic port_reset();
		@(posedge clk);
		trst_n <= 1'b0;
		repeat (4) @(posedge clk);
		trst_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// full scan from idle; pause_at below zero means no pause
	task automatic scan(input bit ir, input int n, input int pause_at, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		dout = '0;
		step(1'b0, 1'b0, q);
		step(1'b1, 1'b0, q);
		if (ir) begin
			step(1'b1, 1'b1, q);
		end
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1 || i == pause_at, din[i], q);
			dout[i] = q;
			if (i == pause_at && i != n - 1) begin
				step(1'b0, ~din[i], q);
				step(1'b0, din[i], q);
				step(1'b1, ~din[i], q);
				step(1'b0, din[i], q);
			end
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b0, q);
		repeat (4) @(posedge clk);
	endtask
endmodule

// *** tb/bst_tap_tb.sv ***
// self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
module bst_tap_tb;
	localparam logic [10:0] MK = 11'h2A5; // arbitrary value
	localparam logic [15:0] PT = 16'h5A3C; // arbitrary value
	localparam logic [3:0] VR = 4'h6; // arbitrary value
	localparam logic [31:0] ID_EXP = {VR, PT, MK, 1'b1};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tck, tms, tdi, trst_n, tdo, oe, extest, flt, was_reset;
	logic [7:0] cap_in = 8'h00;
	logic [7:0] drive;
	logic [3:0] ci;
	logic [31:0] q, d;
	logic [7:0] capv, old;
	logic [3:0] code;
	int miscompares = 0;
	int n_tests = 0;
	int seed;

	always #50 clk = ~clk;

	bst_ctl_model i_ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

	bst_tap #(.BSR_W(8), .MAKER_ID(MK), .PART_ID(PT), .VERSION_ID(VR)) i_dut (
		.clk(clk), .rst(rst), .test_clock_input(tck), .test_mode_select(tms), .test_data_in(tdi),
		.test_reset_n(trst_n), .test_data_out(tdo), .test_data_out_oe(oe), .boundary_capture(cap_in),
		.boundary_drive(drive), .boundary_extest(extest), .outputs_float(flt),
		.port_was_reset(was_reset), .current_instruction(ci));

	function automatic logic [7:0] exp_dr(logic [3:0] c, logic [7:0] din, logic [7:0] cp);
		if (c == bst_pkg::INS_EXTEST || c == bst_pkg::INS_SAMPLE) begin
			return cp;
		end
		if (c == bst_pkg::INS_IDCODE) begin
			return ID_EXP[7:0];
		end
		return {din[6:0], 1'b0};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic print_verdict();
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// about 470 scan steps of 0.8 us are expected
	initial begin
		#2000000;
		miscompares++;
		print_verdict();
	end

	initial begin
		seed = 32'h3DBA6C33;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		check(was_reset, 1'b0, "gate before port reset");
		i_ctl.port_reset();
		check(was_reset, 1'b1, "gate after port reset");
		check(ci, bst_pkg::IR_RESET, "reset instruction");
		d = $random(seed);
		i_ctl.scan(1'b0, 32, 13, d, q);
		check(q, ID_EXP, "identification scan");
		for (int k = 0; k < 16; k++) begin
			code = k[3:0];
			i_ctl.scan(1'b1, 4, (k % 4 == 1) ? 1 : -1, {28'h0, code}, q);
			check(q[1:0], bst_pkg::IR_CAPTURE, "instruction capture");
			check(ci, code, "current instruction");
			check(extest, code == bst_pkg::INS_EXTEST, "extest flag");
			check(flt, code == bst_pkg::INS_FLOAT, "float flag");
			check(oe, 1'b0, "serial output idle after scan");
			if (code != bst_pkg::INS_FLOAT) begin
				d = $random(seed);
				capv = 8'($random(seed));
				@(posedge clk);
				cap_in <= capv;
				old = drive;
				i_ctl.scan(1'b0, 8, (k % 3 == 0) ? 3 : -1, d, q);
				check(q[7:0], exp_dr(code, d[7:0], capv), "data scan");
				check(drive, (code <= 4'h1) ? d[7:0] : old, "output latches");
			end
		end
		// park in shift-data, then count mode-select ones up to the reset state
		i_ctl.step(1'b0, 1'b0, q[0]);
		i_ctl.step(1'b1, 1'b0, q[0]);
		i_ctl.step(1'b0, 1'b0, q[0]);
		i_ctl.step(1'b0, 1'b0, q[0]);
		i_ctl.step(1'b1, 1'b1, q[0]);
		check(oe, 1'b1, "serial output enabled in shift");
		for (int k = 0; k < 3; k++) begin
			i_ctl.step(1'b1, 1'b1, q[0]);
		end
		repeat (5) @(posedge clk);
		check(ci, bst_pkg::INS_BYPASS, "four ones keep instruction");
		i_ctl.step(1'b1, 1'b0, q[0]);
		repeat (5) @(posedge clk);
		check(ci, bst_pkg::IR_RESET, "five ones reset");
		print_verdict();
	end
endmodule
